// file: rtl/dsr_pkg.sv
//
// Purpose : constants for the device status register bank
// Assumes : 7-bit register addresses, 16-bit register images, 25 MHz clock
// Notes   : restart keep masks are applied to the register images
//
package dsr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [6:0]  ADDR_THERMAL    = 7'h41;
    localparam logic [6:0]  ADDR_DEV_INFO   = 7'h42;
    localparam logic [6:0]  ADDR_LINK       = 7'h43;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and restart keep masks
    localparam logic [15:0] REG_RESET       = 16'h0000;
    localparam logic [15:0] THERM_KEEP      = 16'h000F;
    localparam logic [15:0] DEV_KEEP        = 16'h03DF;
    localparam logic [15:0] LINK_KEEP       = 16'h007F;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int          THERM_PREWARN   = 0;
    localparam int          THERM_MOD_OT    = 1;
    localparam int          THERM_SEVERE    = 2;
    localparam int          THERM_SAFE      = 3;
    localparam int          DEV_RSV_LSB     = 10;
    localparam int          LINK_LSB        = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // encodings
    localparam logic [1:0]  PRIOR_CLEARED   = 2'h0;
    localparam logic [1:0]  PRIOR_RESTART   = 2'h1;
    localparam logic [1:0]  PRIOR_SLEEP     = 2'h2;
    localparam logic [1:0]  LINK_NONE       = 2'h0;
    localparam logic [1:0]  LINK_XCVR_TSD   = 2'h1;
    localparam logic [1:0]  LINK_TXD_STUCK  = 2'h2;
    localparam logic [1:0]  LINK_BUS_STUCK  = 2'h3;
    localparam logic [1:0]  WD_SATURATED    = 2'h3;
    localparam logic [4:0]  SAFE_STREAK     = 5'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int          TMR_W           = 31;
    localparam longint      CLK_HZ          = 64'h0000_0000_017D_7840;
    localparam longint      LONG_WAIT_S     = 64'h0000_0000_0000_0040;
    localparam longint      SHORT_WAIT_S    = 64'h0000_0000_0000_0001;
    localparam logic [TMR_W-1:0] LONG_WAIT_CYC  = TMR_W'(LONG_WAIT_S * CLK_HZ);
    localparam logic [TMR_W-1:0] SHORT_WAIT_CYC = TMR_W'(SHORT_WAIT_S * CLK_HZ);

    typedef enum logic {
        TMR_IDLE,
        TMR_WAIT
    } dsr_tmr_e;

endpackage : dsr_pkg

// file: rtl/dsr_wait_timer.sv
//
// Purpose : severe overtemperature waiting timer, short or long length
// Assumes : start is a one-cycle pulse on the system clock
// Notes   : a new start while waiting reloads the count
//
`timescale 1ns/10ps
module dsr_wait_timer #(
    parameter logic [dsr_pkg::TMR_W-1:0] SHORT_CYC = dsr_pkg::SHORT_WAIT_CYC,
    parameter logic [dsr_pkg::TMR_W-1:0] LONG_CYC  = dsr_pkg::LONG_WAIT_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // control
    input  wire logic start,
    input  wire logic long_sel,
    // status
    output logic      busy
);
    import dsr_pkg::*;

    typedef struct packed {
        dsr_tmr_e          state;
        logic [TMR_W-1:0]  cnt;
    } dsr_tmr_s;

    dsr_tmr_s st;
    dsr_tmr_s next_st;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        case (st.state)
            TMR_IDLE: begin
                next_st.cnt = '0;
            end
            TMR_WAIT: begin
                next_st.cnt = st.cnt - TMR_W'(1);
                if (st.cnt == TMR_W'(1)) begin
                    next_st.state = TMR_IDLE;
                end
            end
            default: begin
                next_st.state = TMR_IDLE;
            end
        endcase
        if (start) begin
            next_st.state = TMR_WAIT;
            next_st.cnt   = long_sel ? LONG_CYC : SHORT_CYC;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{state: TMR_IDLE, cnt: '0};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign busy = (st.state == TMR_WAIT);

endmodule : dsr_wait_timer

// file: rtl/dsr_status_regs.sv
//
// Purpose : thermal, device information and link fault status registers
// Assumes : event inputs come from logic on the system clock, one-cycle pulses
// Notes   : read data is answered one cycle after the access strobe
//
`timescale 1ns/10ps
// Summary of operation
// - seventeenth consecutive severe event: safe flag, 64s wait
// - severe overtemp sets bit 2, requests fail-safe
// - module overtemp sets bit 1, disables that module
// - thermal prewarning sets bit 0
// - thermal flags stay set after condition ends
// - thermal register cleared on reset, restart keeps 3:0
// - bits 9/8 show CRC enable and failure
// - CRC toggle sequence never sets CRC failure
// - prior-state codes 00/01/10, host clears actively
// - sleep attempt without cleared wakes reports sleep code
// - bit 4 shows development mode, else zero
// - watchdog failure counter saturates, device clears itself
// - invalid serial command sets bit 1
// - info register cleared on reset, restart keeps fields
// - link fault field encodes three fault kinds
// - link register cleared on reset, restart keeps 6:0
// - reserved info bits read zero, writes ignored
module dsr_status_regs #(
    parameter int                        N_MOD          = 3,
    parameter logic [dsr_pkg::TMR_W-1:0] LONG_WAIT_CYC  = dsr_pkg::LONG_WAIT_CYC,
    parameter logic [dsr_pkg::TMR_W-1:0] SHORT_WAIT_CYC = dsr_pkg::SHORT_WAIT_CYC
) (
    // clock, reset, enable
    input  wire logic             CLK_SYS,
    input  wire logic             RESETN,
    input  wire logic             CE,
    // reset kinds
    input  wire logic             SOFT_RST,
    input  wire logic             RESTART,
    // register access
    input  wire logic [6:0]       ADDR,
    input  wire logic             RD_REQ,
    input  wire logic             CLR_REQ,
    output logic      [15:0]      RDATA,
    output logic                  RVALID,
    output logic                  RD_NO_CRC,
    // thermal events
    input  wire logic             PREWARN_EV,
    input  wire logic [N_MOD-1:0] MOD_OT_EV,
    input  wire logic             SEVERE_OT_EV,
    input  wire logic             SEVERE_OT_CLEAR,
    // device events and levels
    input  wire logic             CRC_EN,
    input  wire logic             CRC_FAIL_EV,
    input  wire logic             CRC_SEQ,
    input  wire logic             DEV_MODE,
    input  wire logic             WDOG_FAIL_EV,
    input  wire logic             WD_CLR_EV,
    input  wire logic             SPI_CMD_ERR,
    input  wire logic             RESTART_FAIL_EV,
    input  wire logic             FAILSAFE_WAKE_EV,
    input  wire logic             SLEEP_EV,
    input  wire logic             SLEEP_TRY_EV,
    // link events
    input  wire logic             LINK_TSD_EV,
    input  wire logic             TXD_STUCK_EV,
    input  wire logic             BUS_STUCK_EV,
    // actions
    output logic                  FAILSAFE_REQ,
    output logic      [N_MOD-1:0] MOD_DISABLE,
    output logic                  SEVERE_WAIT
);
    import dsr_pkg::*;

    typedef struct packed {
        logic [3:0]       therm;
        logic             crc_fail;
        logic [1:0]       prior;
        logic [1:0]       wd_cnt;
        logic             spi_err;
        logic             failure;
        logic [1:0]       link;
        logic [4:0]       streak;
        logic [N_MOD-1:0] mod_dis;
        logic             failsafe_req;
        logic [15:0]      rdata;
        logic             rvalid;
        logic             rd_no_crc;
    } dsr_state_s;

    dsr_state_s       st;
    dsr_state_s       next_st;
    logic             rst_meta;
    logic             rst_n;
    logic [15:0]      therm_img;
    logic [15:0]      dev_img;
    logic [15:0]      link_img;
    logic             clr_therm;
    logic             clr_dev;
    logic             clr_link;
    logic [N_MOD-1:0] next_mod_dis;
    logic [4:0]       streak_inc;
    logic             wait_start;
    logic             wait_long;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register images
    // reserved bits zero
    assign therm_img = {12'h000, st.therm};
    assign dev_img   = {6'h00, CRC_EN, st.crc_fail, st.prior, 1'b0, DEV_MODE,
                        st.wd_cnt, st.spi_err, st.failure};
    assign link_img  = {9'h000, st.link, 5'h00};

    assign clr_therm = CLR_REQ && (ADDR == ADDR_THERMAL);
    assign clr_dev   = CLR_REQ && (ADDR == ADDR_DEV_INFO);
    assign clr_link  = CLR_REQ && (ADDR == ADDR_LINK);

    assign streak_inc = (st.streak == 5'h1F) ? st.streak : st.streak + 5'h01;
    assign wait_start = SEVERE_OT_EV && !SOFT_RST;
    assign wait_long  = streak_inc > SAFE_STREAK;

    ////////////////////////////////////////////////////////////////////////////////
    // per-module disable, held until the thermal register is read-cleared
    for (genvar i = 0; i < N_MOD; i++) begin : g_mod
        assign next_mod_dis[i] = MOD_OT_EV[i] || (st.mod_dis[i] && !clr_therm);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st              = st;
        next_st.failsafe_req = 1'b0;
        next_st.rvalid       = 1'b0;
        next_st.rd_no_crc    = 1'b0;
        next_st.mod_dis      = next_mod_dis;

        // read answer; image is taken before this cycle's clear
        if (RD_REQ || CLR_REQ) begin
            next_st.rvalid = 1'b1;
            case (ADDR)
                ADDR_THERMAL:  next_st.rdata = therm_img;
                ADDR_DEV_INFO: begin
                    next_st.rdata     = dev_img;
                    next_st.rd_no_crc = 1'b1;
                end
                ADDR_LINK:     next_st.rdata = link_img;
                default:       next_st.rdata = REG_RESET;
            endcase
        end

        if (clr_therm) begin
            next_st.therm = 4'h0;
        end
        // serial error only cleared by command
        if (clr_dev) begin
            next_st.crc_fail = 1'b0;
            next_st.prior    = PRIOR_CLEARED;
            next_st.spi_err  = 1'b0;
            next_st.failure  = 1'b0;
        end
        if (clr_link) begin
            next_st.link = LINK_NONE;
        end

        if (RESTART) begin
            next_st.therm = next_st.therm & THERM_KEEP[3:0];
            next_st.link  = next_st.link & LINK_KEEP[LINK_LSB+1:LINK_LSB];
            next_st.prior = next_st.prior & DEV_KEEP[7:6];
        end

        // flags only set here, never auto-cleared
        if (PREWARN_EV) begin
            next_st.therm[THERM_PREWARN] = 1'b1;
        end
        if (|MOD_OT_EV) begin
            next_st.therm[THERM_MOD_OT] = 1'b1;
        end
        if (SEVERE_OT_CLEAR) begin
            next_st.streak = 5'h00;
        end
        if (SEVERE_OT_EV) begin
            next_st.therm[THERM_SEVERE] = 1'b1;
            next_st.failsafe_req        = 1'b1;
            next_st.streak              = streak_inc;
            if (wait_long) begin
                next_st.therm[THERM_SAFE] = 1'b1;
            end
        end

        if (CRC_FAIL_EV && !CRC_SEQ) begin
            next_st.crc_fail = 1'b1;
        end
        if (WD_CLR_EV) begin
            next_st.wd_cnt = 2'h0;
        end else if (WDOG_FAIL_EV && st.wd_cnt != WD_SATURATED) begin
            next_st.wd_cnt = st.wd_cnt + 2'h1;
        end
        if (SPI_CMD_ERR) begin
            next_st.spi_err = 1'b1;
        end
        if (WDOG_FAIL_EV || SEVERE_OT_EV || RESTART_FAIL_EV) begin
            next_st.failure = 1'b1;
        end
        if (SLEEP_EV || SLEEP_TRY_EV) begin
            next_st.prior = PRIOR_SLEEP;
        end else if (RESTART_FAIL_EV || FAILSAFE_WAKE_EV) begin
            next_st.prior = PRIOR_RESTART;
        end

        // link fault encoding, highest code wins
        if (BUS_STUCK_EV) begin
            next_st.link = LINK_BUS_STUCK;
        end else if (TXD_STUCK_EV) begin
            next_st.link = LINK_TXD_STUCK;
        end else if (LINK_TSD_EV) begin
            next_st.link = LINK_XCVR_TSD;
        end

        if (SOFT_RST) begin
            next_st = '0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (CE) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // severe wait timer; trades a 31-bit counter for a plain down-count
    dsr_wait_timer #(
        .SHORT_CYC (SHORT_WAIT_CYC),
        .LONG_CYC  (LONG_WAIT_CYC)
    ) u_wait (
        .clk      (CLK_SYS),
        .rst_n    (rst_n),
        .ce       (CE),
        .start    (wait_start),
        .long_sel (wait_long),
        .busy     (SEVERE_WAIT)
    );

    assign RDATA        = st.rdata;
    assign RVALID       = st.rvalid;
    assign RD_NO_CRC    = st.rd_no_crc;
    assign FAILSAFE_REQ = st.failsafe_req;
    assign MOD_DISABLE  = st.mod_dis;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    AST_PREWARN_SET: assert property (
        CE && PREWARN_EV && !SOFT_RST |=> st.therm[THERM_PREWARN])
        else $error("prewarning flag not set");

    AST_STICKY: assert property (
        st.therm[THERM_PREWARN] && !(CE && (SOFT_RST || clr_therm))
        |=> st.therm[THERM_PREWARN])
        else $error("thermal flag cleared by itself");

    AST_SEVERE_FS: assert property (
        CE && SEVERE_OT_EV && !SOFT_RST
        |=> FAILSAFE_REQ && st.therm[THERM_SEVERE]
        ##1 (!FAILSAFE_REQ || $past(SEVERE_OT_EV) || !$past(CE)))
        else $error("severe event did not request fail-safe");

    AST_MOD_DIS: assert property (
        CE && MOD_OT_EV[0] && !SOFT_RST |=> MOD_DISABLE[0] && st.therm[THERM_MOD_OT])
        else $error("module not disabled on overtemp");

    AST_SAFE_STREAK: assert property (
        CE && SEVERE_OT_EV && !SEVERE_OT_CLEAR && !SOFT_RST && st.streak == SAFE_STREAK
        |=> st.therm[THERM_SAFE] && SEVERE_WAIT)
        else $error("safe state not reached after streak");

    AST_CRC_SEQ: assert property (
        CE && CRC_FAIL_EV && CRC_SEQ && !st.crc_fail |=> !st.crc_fail)
        else $error("crc toggle sequence set crc failure");

    AST_WD_SAT: assert property (
        CE && st.wd_cnt == WD_SATURATED && WDOG_FAIL_EV && !WD_CLR_EV && !SOFT_RST
        |=> st.wd_cnt == WD_SATURATED)
        else $error("watchdog counter wrapped");

    AST_SET_WINS: assert property (
        CE && clr_dev && SPI_CMD_ERR && !SOFT_RST |=> st.spi_err)
        else $error("serial error lost against clear");

    AST_SLEEP_TRY: assert property (
        CE && SLEEP_TRY_EV && !SOFT_RST |=> st.prior == PRIOR_SLEEP)
        else $error("sleep attempt not reported");

    AST_LINK_CODE: assert property (
        CE && TXD_STUCK_EV && !BUS_STUCK_EV && !SOFT_RST |=> st.link == LINK_TXD_STUCK)
        else $error("link fault code wrong");

    AST_RSV_ZERO: assert property (
        RVALID && RD_NO_CRC |-> RDATA[15:DEV_RSV_LSB] == 6'h00 && RDATA[5] == 1'b0)
        else $error("reserved info bits not zero");

    AST_READ_ANS: assert property (
        CE && RD_REQ && !SOFT_RST && ADDR == ADDR_DEV_INFO |=> RVALID && RD_NO_CRC
        && RDATA[9] == $past(CRC_EN) && RDATA[4] == $past(DEV_MODE))
        else $error("info read answer wrong");

    AST_SOFT_CLR: assert property (
        CE && SOFT_RST |=> st.therm == 4'h0 && st.link == LINK_NONE
        && st.prior == PRIOR_CLEARED && !st.failure)
        else $error("soft reset left flags set");

    COV_SAFE: cover property (CE && SEVERE_OT_EV && wait_long);
    COV_RC_DEV: cover property (CE && clr_dev && st.spi_err);
    COV_WD_SAT: cover property (st.wd_cnt == WD_SATURATED);
    COV_LINK: cover property (st.link == LINK_BUS_STUCK);

endmodule : dsr_status_regs

// file: sim/dsr_host_model.sv
//
// Purpose : host side of the status register bank, one access at a time
// Assumes : requests change at the falling edge, answer within four cycles
// Notes   : address lines show the inverse of the last value when idle
//
`timescale 1ns/10ps
module dsr_host_model (
    // clock
    input  wire logic        clk,
    // register access
    output logic      [6:0]  addr,
    output logic             rd_req,
    output logic             clr_req,
    input  wire logic [15:0] rdata,
    input  wire logic        rvalid,
    input  wire logic        no_crc
);
    initial begin
        addr    = 7'h00;
        rd_req  = 1'b0;
        clr_req = 1'b0;
    end

    // explicit clear only: a plain read leaves the flags set, a clear access drops them
    task automatic access(input logic [6:0] a, input logic c, output logic [15:0] d,
                          output logic nc, output logic ok);
        int n;
        @(negedge clk);
        addr    = a;
        rd_req  = !c;
        clr_req = c;
        @(negedge clk);
        rd_req  = 1'b0;
        clr_req = 1'b0;
        addr    = ~a;
        n       = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        ok = rvalid;
        d  = rdata;
        nc = no_crc;
    endtask : access
endmodule : dsr_host_model

// file: sim/tb_top.sv
//
// Purpose : self-checking bench of the status register bank
// Assumes : short waiting lengths of 10 and 40 cycles
// Notes   : random module masks and watchdog counts come from a fixed lfsr
//
`timescale 1ns/10ps
module tb_top;
    import dsr_pkg::*;

    logic        clk_sys;
    logic        resetn;
    logic        ce;
    logic [15:0] ev;
    logic [2:0]  mod_ev;
    logic        crc_en;
    logic        crc_seq;
    logic        dev_mode;
    logic [6:0]  addr;
    logic        rd_req;
    logic        clr_req;
    logic [15:0] rdata;
    logic        rvalid;
    logic        no_crc;
    logic        fs_req;
    logic [2:0]  mod_dis;
    logic        sev_wait;
    logic [15:0] lfsr;
    int          n_mismatch;
    int          tests_run;
    int          cycles;
    int          n;

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    dsr_status_regs #(.N_MOD(3), .LONG_WAIT_CYC(31'd40), .SHORT_WAIT_CYC(31'd10))
    i_dsr_status_regs (
        .CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce),
        .SOFT_RST(ev[14]), .RESTART(ev[15]),
        .ADDR(addr), .RD_REQ(rd_req), .CLR_REQ(clr_req),
        .RDATA(rdata), .RVALID(rvalid), .RD_NO_CRC(no_crc),
        .PREWARN_EV(ev[0]), .MOD_OT_EV(mod_ev), .SEVERE_OT_EV(ev[1]),
        .SEVERE_OT_CLEAR(ev[2]), .CRC_EN(crc_en), .CRC_FAIL_EV(ev[3]),
        .CRC_SEQ(crc_seq), .DEV_MODE(dev_mode), .WDOG_FAIL_EV(ev[4]),
        .WD_CLR_EV(ev[5]), .SPI_CMD_ERR(ev[6]), .RESTART_FAIL_EV(ev[7]),
        .FAILSAFE_WAKE_EV(ev[8]), .SLEEP_EV(ev[9]), .SLEEP_TRY_EV(ev[10]),
        .LINK_TSD_EV(ev[11]), .TXD_STUCK_EV(ev[12]), .BUS_STUCK_EV(ev[13]),
        .FAILSAFE_REQ(fs_req), .MOD_DISABLE(mod_dis), .SEVERE_WAIT(sev_wait)
    );

    dsr_host_model i_dsr_host_model (
        .clk(clk_sys), .addr(addr), .rd_req(rd_req), .clr_req(clr_req),
        .rdata(rdata), .rvalid(rvalid), .no_crc(no_crc)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [15:0] dev_img(input logic ce, input logic cf,
        input logic [1:0] pr, input logic dm, input logic [1:0] wd,
        input logic se, input logic f);
        return {6'h00, ce, cf, pr, 1'b0, dm, wd, se, f};
    endfunction : dev_img

    task automatic end_of_test();
        $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [6:0] a, input logic c, input logic [15:0] e);
        logic [15:0] d;
        logic        nc;
        logic        ok;
        i_dsr_host_model.access(a, c, d, nc, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, e);
        chk({15'h0000, nc}, {15'h0000, a == ADDR_DEV_INFO});
    endtask : rd

    task automatic fire(input int i);
        @(negedge clk_sys) ev[i] = 1'b1;
        @(negedge clk_sys) ev[i] = 1'b0;
    endtask : fire

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0; ev = 16'h0000; mod_ev = 3'h0; crc_en = 1'b0;
        crc_seq = 1'b0; dev_mode = 1'b0; lfsr = 16'h002F;
        ce = 1'b1;
        n_mismatch = 0; tests_run = 0; cycles = 0;
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(ADDR_THERMAL, 0, 16'h0000);
        rd(ADDR_DEV_INFO, 0, 16'h0000);
        rd(ADDR_LINK, 0, 16'h0000);
        rd(7'h44, 0, 16'h0000);
        // thermal flags, module disable with a random mask
        fire(0);
        lfsr = lfsr_next(lfsr);
        @(negedge clk_sys) mod_ev = lfsr[2:0] | 3'h1;
        @(negedge clk_sys) chk({13'h0000, mod_dis}, {13'h0000, lfsr[2:0] | 3'h1});
        mod_ev = 3'h0;
        fire(1);
        chk({15'h0000, fs_req}, 16'h0001);
        chk({15'h0000, sev_wait}, 16'h0001);
        @(negedge clk_sys) chk({15'h0000, fs_req}, 16'h0000);
        rd(ADDR_THERMAL, 0, 16'h0007);
        rd(ADDR_THERMAL, 1, 16'h0007);
        rd(ADDR_THERMAL, 0, 16'h0000);
        chk({13'h0000, mod_dis}, 16'h0000);
        repeat (10) @(negedge clk_sys);
        chk({15'h0000, sev_wait}, 16'h0000);
        // consecutive severe events, safe state on the seventeenth
        fire(2);
        repeat (16) fire(1);
        rd(ADDR_THERMAL, 1, 16'h0004);
        fire(1);
        rd(ADDR_THERMAL, 0, 16'h000C);
        repeat (20) @(negedge clk_sys);
        chk({15'h0000, sev_wait}, 16'h0001);
        repeat (30) @(negedge clk_sys);
        chk({15'h0000, sev_wait}, 16'h0000);
        rd(ADDR_THERMAL, 1, 16'h000C);
        rd(ADDR_DEV_INFO, 1, 16'h0001);
        // crc, development mode and serial error flags
        @(negedge clk_sys) crc_en = 1'b1;
        dev_mode = 1'b1;
        crc_seq = 1'b1;
        fire(3);
        crc_seq = 1'b0;
        rd(ADDR_DEV_INFO, 0, dev_img(1, 0, 2'h0, 1, 2'h0, 0, 0));
        fire(3);
        fire(6);
        rd(ADDR_DEV_INFO, 1, dev_img(1, 1, 2'h0, 1, 2'h0, 1, 0));
        rd(ADDR_DEV_INFO, 0, dev_img(1, 0, 2'h0, 1, 2'h0, 0, 0));
        // watchdog counter with random event counts
        for (int j = 0; j < 3; j++) begin
            lfsr = lfsr_next(lfsr);
            n = lfsr % 7;
            repeat (n) fire(4);
            rd(ADDR_DEV_INFO, 1, dev_img(1, 0, 2'h0, 1, (n > 3) ? 2'h3 : 2'(n), 0, n != 0));
            rd(ADDR_DEV_INFO, 0, dev_img(1, 0, 2'h0, 1, (n > 3) ? 2'h3 : 2'(n), 0, 0));
            fire(5);
            rd(ADDR_DEV_INFO, 0, dev_img(1, 0, 2'h0, 1, 2'h0, 0, 0));
        end
        // prior-state codes for restart, fail-safe wake, sleep and sleep attempt
        for (int i = 0; i < 4; i++) begin
            fire(7 + i);
            rd(ADDR_DEV_INFO, 1, dev_img(1, 0, (i < 2) ? PRIOR_RESTART : PRIOR_SLEEP,
                                         1, 2'h0, 0, i == 0));
            rd(ADDR_DEV_INFO, 0, dev_img(1, 0, PRIOR_CLEARED, 1, 2'h0, 0, 0));
        end
        // link fault codes
        for (int i = 0; i < 3; i++) begin
            fire(11 + i);
            rd(ADDR_LINK, 1, 16'((i + 1) << LINK_LSB));
            rd(ADDR_LINK, 0, 16'h0000);
        end
        // restart keeps stored fields, soft reset clears them
        @(negedge clk_sys) crc_en = 1'b0;
        dev_mode = 1'b0;
        fire(0);
        fire(6);
        fire(13);
        fire(15);
        rd(ADDR_THERMAL, 0, 16'h0001);
        rd(ADDR_DEV_INFO, 0, dev_img(0, 0, 2'h0, 0, 2'h0, 1, 0));
        rd(ADDR_LINK, 0, 16'h0060);
        fire(14);
        rd(ADDR_THERMAL, 0, 16'h0000);
        rd(ADDR_DEV_INFO, 0, 16'h0000);
        rd(ADDR_LINK, 0, 16'h0000);
        // an event while the enable is low must leave no trace
        @(negedge clk_sys) ce = 1'b0;
        ev[0] = 1'b1;
        @(negedge clk_sys) ev[0] = 1'b0;
        ce = 1'b1;
        rd(ADDR_THERMAL, 0, 16'h0000);
        end_of_test();
    end
endmodule : tb_top
